// ### logic/adcrm_defines.svh
/*
 * offsets, field positions, reset values and codes of the converter
 * register bank; included by the channel map, output pin and register bank modules.
 */
`ifndef ADCRM_DEFINES_SVH
`define ADCRM_DEFINES_SVH

// ***********************************************************************
// register-select codes
// ***********************************************************************
`define ADCRM_RS_RESULT 3'h3
`define ADCRM_RS_IDENT 3'h4
`define ADCRM_RS_OUTCTL 3'h5

// ***********************************************************************
// reset values
// ***********************************************************************
`define ADCRM_RESULT_RST 24'h000000
`define ADCRM_OUTCTL_RST 8'h00
`define ADCRM_CODE_RST 4'h0

// ***********************************************************************
// output control field positions
// ***********************************************************************
`define ADCRM_OC_BIT7 7
`define ADCRM_OC_BRIDGE 6
`define ADCRM_OC_HI_EN 5
`define ADCRM_OC_LO_EN 4

// ***********************************************************************
// channel codes and input numbers
// ***********************************************************************
`define ADCRM_CODE_TEMP 4'h8
`define ADCRM_CODE_SHORT 4'h9
`define ADCRM_IN_TEMP 4'h0
`define ADCRM_IN_AIN2 4'h2
`define ADCRM_IN_COMMON 4'h9
`define ADCRM_CAL_SHARED 3'h4
`define ADCRM_SEL_SHORT 9
`define ADCRM_SEL_TEMP 8

// ***********************************************************************
// read lengths in bits
// ***********************************************************************
`define ADCRM_LEN_BYTE 6'h08
`define ADCRM_LEN_WORD 6'h18
`define ADCRM_LEN_WORD_STAT 6'h20

`endif

// ### logic/adcrm_pkg.sv
/*
 * types shared by the register bank modules.
 * assumes nothing of its surroundings.
 */
`default_nettype none

package adcrm_pkg;
   // decoded channel selection
   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      logic [3:0] code;
      logic [2:0] cal_pair;
      logic cal_valid;
   } adcrm_map_t;
endpackage : adcrm_pkg

`default_nettype wire

// ### logic/adcrm_if.sv
/*
 * carriers between the top of the register bank and its two helpers.
 * assumes the package is compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

interface adcrm_map_if;
   logic [9:0] sel;
   logic pseudo;
   adcrm_pkg::adcrm_map_t map;
   modport requester (output sel, output pseudo, input map);
   modport mapper (input sel, input pseudo, output map);
endinterface : adcrm_map_if

interface adcrm_gpo_if;
   logic [7:0] ctl;
   logic [7:0] readback;
   modport owner (output ctl, input readback);
   modport driver (input ctl, output readback);
endinterface : adcrm_gpo_if

`default_nettype wire

// ### logic/adcrm_chan_map.sv
/*
 * maps a one-hot channel selection to input pair, channel code and
 * calibration pair. purely combinational.
 * assumes at most one selection bit is set.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcrm_defines.svh"

module adcrm_chan_map
(
   adcrm_map_if.mapper m
);
   logic [2:0] idx;
   logic any_ch;

   always_comb
   begin
      idx = 3'h0;
      any_ch = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         if (m.sel[i])
         begin
            idx = 3'(i);
            any_ch = 1'b1;
         end
      end
   end

   always_comb
   begin
      m.map = '0;
      if (m.sel[`ADCRM_SEL_SHORT])
      begin
         // same input on both sides
         m.map.pos = m.pseudo ? `ADCRM_IN_COMMON : `ADCRM_IN_AIN2;
         m.map.neg = m.map.pos;
         m.map.code = `ADCRM_CODE_SHORT;
         m.map.cal_valid = 1'b1;
      end
      else if (m.sel[`ADCRM_SEL_TEMP])
      begin
         m.map.pos = `ADCRM_IN_TEMP;
         m.map.neg = `ADCRM_IN_TEMP;
         m.map.code = `ADCRM_CODE_TEMP;
      end
      else if (any_ch && !m.pseudo)
      begin
         m.map.pos = {1'b0, idx[1:0], 1'b0} + 4'h1;
         m.map.neg = {1'b0, idx[1:0], 1'b0} + 4'h2;
         m.map.code = {1'b0, idx};
         m.map.cal_pair = {1'b0, idx[1:0]};
         m.map.cal_valid = 1'b1;
      end
      else if (any_ch)
      begin
         m.map.pos = {1'b0, idx} + 4'h1;
         m.map.neg = `ADCRM_IN_COMMON;
         m.map.code = {1'b0, idx};
         m.map.cal_pair = idx[2] ? `ADCRM_CAL_SHARED : {1'b0, idx[1:0]};
         m.map.cal_valid = 1'b1;
      end
   end
endmodule : adcrm_chan_map

`default_nettype wire

// ### logic/adcrm_gpo.sv
/*
 * general-purpose output pins and bridge switch driven from the
 * output control register, with pin read-back.
 * assumes pin levels arrive synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcrm_defines.svh"

module adcrm_gpo
(
   adcrm_gpo_if.driver g,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe_out,
   output logic bridge_out
);
   wire hi_en = g.ctl[`ADCRM_OC_HI_EN];
   wire lo_en = g.ctl[`ADCRM_OC_LO_EN];

   // disabled pairs float and their levels are not driven
   assign pin_oe_out = {hi_en, hi_en, lo_en, lo_en};
   assign pin_out = g.ctl[3:0] & pin_oe_out;
   // power-down does not reach this bit
   assign bridge_out = g.ctl[`ADCRM_OC_BRIDGE];
   // enabled pairs report the real pin level
   wire [3:0] lvl = (pin_in & pin_oe_out) | (g.ctl[3:0] & ~pin_oe_out);
   assign g.readback = {1'b0, g.ctl[6:4], lvl};
endmodule : adcrm_gpo

`default_nettype wire

// ### logic/adcrm_regs.sv
/*
 * register bank of the converter: result, identification and output
 * control registers, ready indicator and channel map outputs.
 * assumes the serial framer presents a register-select code with
 * one-cycle read request, read-complete and write strobes, and that
 * the modulator pulses a conversion with its one-hot channel.
 */
// Operation
// - differential mode maps enables 0-7 to pairs 1/2..7/8, codes 0-7, cal 0-3.
// - temperature gives code 1000 no cal; short gives code 1001, cal 0.
// - pseudo mode maps inputs 1-8 against common; channels 4-7 share cal 4.
// - result register sits at select code 011 and resets to zero.
// - result register is 24-bit, read-only, holds latest conversion.
// - completed result read returns ready pin and bit to not-ready.
// - with append-status set, status byte follows each 24-bit result.
// - identification register at select 100 returns a fixed value.
// - output control register at select 101 is 8-bit read-write.
// - output control register resets to zero.
// - output control register is shifted most significant bit first.
// - bit 7 zero, bridge, high and low pair enables, four levels.
// - enabled pins follow level bits; disabled pairs are tristated.
// - reads of enabled pairs return the actual pin levels.
// - bridge bit closes switch to ground and persists in power-down.
`timescale 1ns/1ps
`default_nettype none
`include "adcrm_defines.svh"

module adcrm_regs
#(
   parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary value
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic wr_strobe_in,
   input wire logic [23:0] wr_data_in,
   input wire logic rd_req_in,
   input wire logic rd_done_in,
   output logic [31:0] rd_data_out,
   output logic [5:0] rd_len_out,
   output logic rd_ack_out,
   input wire logic conv_valid_in,
   input wire logic [23:0] conv_data_in,
   input wire logic [9:0] conv_sel_in,
   input wire logic pseudo_mode_in,
   input wire logic append_status_enable_in,
   input wire logic [2:0] status_flags_in,
   output logic rdy_n_out,
   output logic [7:0] status_out,
   output logic [3:0] mux_pos_out,
   output logic [3:0] mux_neg_out,
   output logic [3:0] channel_code_out,
   output logic [2:0] cal_pair_out,
   output logic cal_valid_out,
   input wire logic [3:0] gpo_pin_in,
   output logic [3:0] gpo_pin_out,
   output logic [3:0] gpo_oe_out,
   output logic bridge_switch_out
);
   // *********************************************************************
   // helpers
   // *********************************************************************
   adcrm_map_if map_if ();
   adcrm_gpo_if gpo_if ();

   assign map_if.sel = conv_sel_in;
   assign map_if.pseudo = pseudo_mode_in;

   adcrm_chan_map u_map
   (
      .m (map_if.mapper)
   );

   adcrm_gpo u_gpo
   (
      .g (gpo_if.driver),
      .pin_in (gpo_pin_in),
      .pin_out (gpo_pin_out),
      .pin_oe_out (gpo_oe_out),
      .bridge_out (bridge_switch_out)
   );

   // *********************************************************************
   // state
   // *********************************************************************
   logic [23:0] result_reg;
   logic [3:0] code_reg;
   logic [7:0] outctl_reg;
   logic rdy_n_reg;
   logic last_rd_result_reg;
   logic [31:0] rd_data_reg;
   logic [5:0] rd_len_reg;
   logic rd_ack_reg;
   adcrm_pkg::adcrm_map_t map_reg;

   assign gpo_if.ctl = outctl_reg;

   // *********************************************************************
   // decode
   // *********************************************************************
   wire sel_result = (reg_sel_in == `ADCRM_RS_RESULT);
   wire sel_ident = (reg_sel_in == `ADCRM_RS_IDENT);
   wire sel_outctl = (reg_sel_in == `ADCRM_RS_OUTCTL);
   // only the output control register takes writes
   wire outctl_we = wr_strobe_in && sel_outctl;
   // bit 7 is held at zero whatever is written
   wire [7:0] outctl_next = {1'b0, wr_data_in[6:0]};
   wire [7:0] status_byte = {rdy_n_reg, status_flags_in, code_reg};
   // a new conversion wins over a read completing in the same cycle
   wire read_done = rd_done_in && last_rd_result_reg;
   wire rdy_n_next = conv_valid_in ? 1'b0 : (read_done ? 1'b1 : rdy_n_reg);

   // read word is left aligned so bit 31 leaves first
   wire [31:0] rd_word =
      sel_result ? {result_reg, append_status_enable_in ? status_byte
                                                        : 8'h00} :
      sel_ident ? {ID_VALUE, 24'h000000} :
      sel_outctl ? {gpo_if.readback, 24'h000000} :
      32'h00000000;
   wire [5:0] rd_len =
      !sel_result ? `ADCRM_LEN_BYTE :
      append_status_enable_in ? `ADCRM_LEN_WORD_STAT : `ADCRM_LEN_WORD;

   // *********************************************************************
   // registers
   // *********************************************************************
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         result_reg <= `ADCRM_RESULT_RST;
         code_reg <= `ADCRM_CODE_RST;
         outctl_reg <= `ADCRM_OUTCTL_RST;
         rdy_n_reg <= 1'b1;
      end
      else
      begin
         if (conv_valid_in)
         begin
            result_reg <= conv_data_in;
            code_reg <= map_if.map.code;
         end
         if (outctl_we)
            outctl_reg <= outctl_next;
         rdy_n_reg <= rdy_n_next;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rd_data_reg <= 32'h00000000;
         rd_len_reg <= `ADCRM_LEN_BYTE;
         rd_ack_reg <= 1'b0;
         last_rd_result_reg <= 1'b0;
         map_reg <= '0;
      end
      else
      begin
         rd_ack_reg <= rd_req_in;
         if (rd_req_in)
         begin
            rd_data_reg <= rd_word;
            rd_len_reg <= rd_len;
            last_rd_result_reg <= sel_result;
         end
         map_reg <= map_if.map;
      end
   end

   assign rd_data_out = rd_data_reg;
   assign rd_len_out = rd_len_reg;
   assign rd_ack_out = rd_ack_reg;
   assign rdy_n_out = rdy_n_reg;
   assign status_out = status_byte;
   assign mux_pos_out = map_reg.pos;
   assign mux_neg_out = map_reg.neg;
   assign channel_code_out = map_reg.code;
   assign cal_pair_out = map_reg.cal_pair;
   assign cal_valid_out = map_reg.cal_valid;

   // *********************************************************************
   // checks
   // *********************************************************************
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence conv_then_read_s;
      conv_valid_in ##1 !conv_valid_in
      ##1 (!conv_valid_in && rd_req_in && sel_result);
   endsequence

   sequence outctl_wr_then_rd_s;
      (outctl_we && !rd_req_in) ##1 (!wr_strobe_in && !rd_req_in)
      ##1 (!wr_strobe_in && rd_req_in && sel_outctl);
   endsequence

   diff_map_a: assert property (
      (conv_sel_in == 10'h010 && !pseudo_mode_in)
      |=> (mux_pos_out == 4'h1 && mux_neg_out == 4'h2 &&
           channel_code_out == 4'h4 && cal_pair_out == 3'h0))
      else $error("differential channel 4 mapped wrongly");

   temp_map_a: assert property (
      (conv_sel_in == 10'h100)
      |=> (channel_code_out == 4'h8 && !cal_valid_out))
      else $error("temperature channel mapped wrongly");

   short_map_a: assert property (
      (conv_sel_in == 10'h200) |=> (channel_code_out == 4'h9 &&
           cal_pair_out == 3'h0 && mux_pos_out == mux_neg_out))
      else $error("shorted channel mapped wrongly");

   pseudo_map_a: assert property (
      (conv_sel_in == 10'h040 && pseudo_mode_in)
      |=> (mux_pos_out == 4'h7 && mux_neg_out == 4'h9 &&
           channel_code_out == 4'h6 && cal_pair_out == 3'h4))
      else $error("pseudo channel 6 mapped wrongly");

   result_read_a: assert property (
      conv_then_read_s |=> (rd_data_out[31:8] == $past(conv_data_in, 3) &&
                            rd_ack_out))
      else $error("result read does not return latest conversion");

   ready_release_a: assert property (
      (read_done && !conv_valid_in) |=> rdy_n_out)
      else $error("ready not released after result read");

   append_status_a: assert property (
      (rd_req_in && sel_result && append_status_enable_in)
      |=> (rd_len_out == 6'h20 && rd_data_out[7:0] == $past(status_byte)))
      else $error("status byte not appended to result");

   ident_read_a: assert property (
      (rd_req_in && sel_ident)
      |=> (rd_data_out[31:24] == ID_VALUE && rd_len_out == 6'h08))
      else $error("identification read wrong");

   outctl_rw_a: assert property (
      outctl_wr_then_rd_s |=> (rd_data_out[30:28] == $past(wr_data_in[6:4], 3)
                               && !rd_data_out[31]))
      else $error("output control read-back differs from write");

   outctl_reset_a: assert property (
      $past(rst_in) |-> (outctl_reg == 8'h00 && result_reg == 24'h000000))
      else $error("registers not cleared by reset");

   pin_follow_a: assert property (
      (outctl_we && wr_data_in[5]) |=> (gpo_oe_out[3:2] == 2'b11 &&
                        gpo_pin_out[3:2] == $past(wr_data_in[3:2])))
      else $error("enabled pins do not follow level bits");

   pin_float_a: assert property (
      (outctl_we && !wr_data_in[4]) |=> (gpo_oe_out[1:0] == 2'b00))
      else $error("disabled pins still driven");

   pin_readback_a: assert property (
      (rd_req_in && sel_outctl && gpo_oe_out[0])
      |=> (rd_data_out[24] == $past(gpo_pin_in[0])))
      else $error("read-back ignores actual pin level");

   bridge_ctl_a: assert property (
      outctl_we |=> (bridge_switch_out == $past(wr_data_in[6])))
      else $error("bridge switch does not follow its bit");

   ro_write_a: assert property (
      (wr_strobe_in && !sel_outctl && !conv_valid_in && !rd_done_in)
      |=> ($stable(outctl_reg) && $stable(result_reg) && $stable(rdy_n_out)))
      else $error("write to read-only register changed state");

   result_len_a: assert property (
      (rd_req_in && sel_result && !append_status_enable_in)
      |=> (rd_len_out == 6'h18 && rd_data_out[7:0] == 8'h00))
      else $error("plain result read has wrong length");

   short_code_a: assert property (
      (conv_valid_in && conv_sel_in == 10'h200)
      |=> (status_out[3:0] == 4'h9))
      else $error("status code does not name shorted channel");

   lo_pins_follow_a: assert property (
      (outctl_we && wr_data_in[4]) |=> (gpo_oe_out[1:0] == 2'b11 &&
                        gpo_pin_out[1:0] == $past(wr_data_in[1:0])))
      else $error("enabled low pins do not follow level bits");

   hi_pins_float_a: assert property (
      (outctl_we && !wr_data_in[5])
      |=> (gpo_oe_out[3:2] == 2'b00 && gpo_pin_out[3:2] == 2'b00))
      else $error("disabled high pins still driven");

   bit7_zero_a: assert property (
      outctl_we |=> !outctl_reg[7])
      else $error("output control bit 7 stored as one");
endmodule : adcrm_regs

`default_nettype wire

// ### dv/adcrm_host.sv
/*
 * host model of the register port: one-cycle write, read and
 * read-finished strobes, read answers collected on rd_ack_in.
 * assumes requests are launched 1 ns after the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module adcrm_host
(
   input wire logic ref_clk_in,
   output logic [2:0] reg_sel_out,
   output logic wr_strobe_out,
   output logic [23:0] wr_data_out,
   output logic rd_req_out,
   output logic rd_done_out,
   input wire logic [31:0] rd_data_in,
   input wire logic [5:0] rd_len_in,
   input wire logic rd_ack_in
);
   // ********************
   // requests
   // ********************
   initial
   begin
      reg_sel_out = 3'h0;
      wr_strobe_out = 1'b0;
      wr_data_out = 24'h000000;
      rd_req_out = 1'b0;
      rd_done_out = 1'b0;
   end

   task write_reg(input logic [2:0] sel, input logic [7:0] val,
      input logic keep);
      begin
         @(posedge ref_clk_in);
         #1;
         reg_sel_out = sel;
         wr_data_out = {16'h0000, keep ? {1'b0, val[6:0]} : val};
         wr_strobe_out = 1'b1;
         @(posedge ref_clk_in);
         #1;
         wr_strobe_out = 1'b0;
         // released data no longer shows the written value
         wr_data_out = ~wr_data_out;
      end
   endtask : write_reg

   task read_reg(input logic [2:0] sel, output logic [31:0] data,
      output logic [5:0] len, output logic ok);
      int i;
      begin
         @(posedge ref_clk_in);
         #1;
         reg_sel_out = sel;
         rd_req_out = 1'b1;
         @(posedge ref_clk_in);
         #1;
         rd_req_out = 1'b0;
         ok = 1'b0;
         i = 0;
         while (!ok && i < 4)
         begin
            if (rd_ack_in === 1'b1)
            begin
               ok = 1'b1;
               data = rd_data_in;
               len = rd_len_in;
            end
            else
            begin
               @(posedge ref_clk_in);
               #1;
               i++;
            end
         end
      end
   endtask : read_reg

   task finish_read;
      begin
         @(posedge ref_clk_in);
         #1;
         reg_sel_out = 3'h3;
         rd_done_out = 1'b1;
         @(posedge ref_clk_in);
         #1;
         rd_done_out = 1'b0;
      end
   endtask : finish_read
endmodule : adcrm_host

`default_nettype wire

// ### dv/adc_channel_map_and_result_regs_test.sv
/*
 * self-checking bench of the register bank with a host model.
 * assumes the design files and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_channel_map_and_result_regs_test;
   localparam logic [7:0] ID_EXP = 8'h3c; // arbitrary value
   logic ref_clk = 1'b0;
   logic rst, wr_strobe, rd_req, rd_done, rd_ack, conv_valid, pseudo;
   logic append, rdy_n, calv, bridge;
   logic [2:0] reg_sel, flags, cal;
   logic [23:0] wr_data, conv_data;
   logic [31:0] rd_data;
   logic [5:0] rd_len;
   logic [9:0] conv_sel;
   logic [7:0] status;
   logic [3:0] mpos, mneg, code, pin_in, pin_out, pin_oe;
   logic [3:0] ext, stuck_mask, stuck_val;
   int n_errors = 0;
   int n_tests = 0;

   always #10 ref_clk = ~ref_clk;
   // a stuck bit models a pin held by an outside load
   assign pin_in = (stuck_mask & stuck_val) |
      (~stuck_mask & ((pin_oe & pin_out) | (~pin_oe & ext)));

   adcrm_host u_host (.ref_clk_in(ref_clk), .reg_sel_out(reg_sel),
      .wr_strobe_out(wr_strobe), .wr_data_out(wr_data),
      .rd_req_out(rd_req), .rd_done_out(rd_done), .rd_data_in(rd_data),
      .rd_len_in(rd_len), .rd_ack_in(rd_ack));

   adcrm_regs #(.ID_VALUE(ID_EXP)) u_dut (.ref_clk_in(ref_clk),
      .rst_in(rst), .reg_sel_in(reg_sel), .wr_strobe_in(wr_strobe),
      .wr_data_in(wr_data), .rd_req_in(rd_req), .rd_done_in(rd_done),
      .rd_data_out(rd_data), .rd_len_out(rd_len), .rd_ack_out(rd_ack),
      .conv_valid_in(conv_valid), .conv_data_in(conv_data),
      .conv_sel_in(conv_sel), .pseudo_mode_in(pseudo),
      .append_status_enable_in(append), .status_flags_in(flags),
      .rdy_n_out(rdy_n), .status_out(status), .mux_pos_out(mpos),
      .mux_neg_out(mneg), .channel_code_out(code), .cal_pair_out(cal),
      .cal_valid_out(calv), .gpo_pin_in(pin_in), .gpo_pin_out(pin_out),
      .gpo_oe_out(pin_oe), .bridge_switch_out(bridge));

   // ********************
   // shared tasks
   // ********************
   task wrap_up;
      begin
         $display("tests %0d errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask : wrap_up

   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_tests++;
         if (got !== exp)
         begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
               exp);
         end
      end
   endtask : chk

   task rd(input logic [2:0] sel, output logic [31:0] d,
      output logic [5:0] l);
      logic ok;
      begin
         u_host.read_reg(sel, d, l, ok);
         if (!ok)
         begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, 1'b0,
               1'b1);
            wrap_up;
         end
      end
   endtask : rd

   task convert(input logic [23:0] data, input logic [9:0] sel);
      begin
         @(posedge ref_clk);
         #1;
         conv_valid = 1'b1;
         conv_data = data;
         conv_sel = sel;
         @(posedge ref_clk);
         #1;
         conv_valid = 1'b0;
         conv_data = ~data;
      end
   endtask : convert

   // ********************
   // scenarios
   // ********************
   task t_reset;
      logic [31:0] d;
      logic [5:0] l;
      begin
         chk(32'({rdy_n, bridge, pin_oe}), 32'h20);
         rd(3'h3, d, l);
         chk(d, 32'h0);
         rd(3'h4, d, l);
         chk(d, {ID_EXP, 24'h0});
         rd(3'h5, d, l);
         chk(d, 32'h0);
         chk(32'(l), 32'h8);
      end
   endtask : t_reset

   task t_map;
      logic [3:0] p, n, c;
      logic [2:0] cp;
      logic cv;
      int m, s;
      begin
         for (m = 0; m < 2; m++)
            for (s = 0; s < 10; s++)
            begin
               @(posedge ref_clk);
               #1;
               pseudo = m[0];
               conv_sel = 10'h001 << s;
               c = 4'(s);
               cv = (s != 8);
               cp = (s > 7) ? 3'h0 : (m == 1 && s > 3) ? 3'h4 : 3'(s % 4);
               p = (m == 1) ? 4'(s + 1) : 4'(2 * (s % 4) + 1);
               n = (m == 1) ? 4'h9 : p + 4'h1;
               if (s == 8)
               begin
                  p = 4'h0;
                  n = 4'h0;
               end
               if (s == 9)
               begin
                  p = (m == 1) ? 4'h9 : 4'h2;
                  n = p;
               end
               @(posedge ref_clk);
               #1;
               chk(32'({mpos, mneg, code, cal, calv}),
                  32'({p, n, c, cp, cv}));
            end
      end
   endtask : t_map

   task t_result;
      logic [31:0] d;
      logic [5:0] l;
      begin
         append = 1'b0;
         convert(24'ha5c31e, 10'h020);
         chk(32'(status), 32'h55);
         u_host.write_reg(3'h3, 8'hff, 1'b1);
         u_host.write_reg(3'h4, 8'h00, 1'b1);
         rd(3'h4, d, l);
         chk(d, {ID_EXP, 24'h0});
         u_host.finish_read;
         chk(32'(rdy_n), 32'h0);
         rd(3'h3, d, l);
         chk(d, 32'ha5c31e00);
         chk(32'({rdy_n, l}), 32'h18);
         u_host.finish_read;
         chk(32'(rdy_n), 32'h1);
         append = 1'b1;
         convert(24'h0f1e2d, 10'h001);
         convert(24'h3b2a19, 10'h200);
         rd(3'h3, d, l);
         chk(d, 32'h3b2a1959);
         chk(32'(l), 32'h20);
         u_host.finish_read;
         chk(32'(rdy_n), 32'h1);
      end
   endtask : t_result

   task t_gpo;
      logic [31:0] d;
      logic [5:0] l;
      begin
         // bit 7 set on purpose
         u_host.write_reg(3'h5, 8'hff, 1'b0);
         chk(32'({bridge, pin_oe, pin_out}), 32'h1ff);
         rd(3'h5, d, l);
         chk(d, 32'h7f000000);
         ext = 4'h5;
         stuck_mask = 4'h1;
         stuck_val = 4'h1;
         u_host.write_reg(3'h5, 8'h1a, 1'b1);
         chk(32'({bridge, pin_oe, pin_out}), 32'h032);
         rd(3'h5, d, l);
         chk(d, 32'h1b000000);
         u_host.write_reg(3'h5, 8'h40, 1'b1);
         chk(32'({bridge, pin_oe, pin_out}), 32'h100);
         rd(3'h5, d, l);
         chk(d, 32'h40000000);
      end
   endtask : t_gpo

   initial
   begin
      rst = 1'b1;
      conv_valid = 1'b0;
      conv_data = 24'h000000;
      conv_sel = 10'h000;
      pseudo = 1'b0;
      append = 1'b0;
      flags = 3'h5;
      ext = 4'ha;
      stuck_mask = 4'h0;
      stuck_val = 4'h0;
      repeat (5) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_reset;
      t_map;
      t_result;
      t_gpo;
      wrap_up;
   end
endmodule : adc_channel_map_and_result_regs_test

`default_nettype wire
